//--- logic/compositor_defines.vh
`ifndef COMPOSITOR_DEFINES_VH
`define COMPOSITOR_DEFINES_VH

// ----------------------------------------------------------------
// Pixel formats
// ----------------------------------------------------------------
`define MODE_W          2
`define MODE_8BIT       2'h0
`define MODE_16BIT      2'h1
`define MODE_32BIT      2'h2

// ----------------------------------------------------------------
// Multiplexing factors
// ----------------------------------------------------------------
`define FACTOR_W        3
`define FACTOR_MIN      3'h2
`define FACTOR_MAX      3'h5
`define SLOT_FIRST      3'h0
`define SLOT_STEP       3'h1
`define MAX_SUBPIXELS   5

// ----------------------------------------------------------------
// Pixel word layout
// ----------------------------------------------------------------
`define WORD_W          160
`define PIX32_W         32
`define PIX16_W         16
`define PIX8_W          8
`define SEL_W           5

// 16-bit pixel fields
`define P16_RED_HI      15
`define P16_RED_LO      10
`define P16_GRN_HI      9
`define P16_GRN_LO      4
`define P16_BLU_HI      3
`define P16_BLU_LO      0
`define FILL6           2'h0
`define FILL4           4'h0

// 32-bit pixel fields
`define P32_RED_HI      31
`define P32_RED_LO      24
`define P32_GRN_HI      23
`define P32_GRN_LO      16
`define P32_BLU_HI      15
`define P32_BLU_LO      8
`define P32_PSE_HI      7
`define P32_PSE_LO      0

// ----------------------------------------------------------------
// Tables and host port
// ----------------------------------------------------------------
`define TBL_AW          8
`define TBL_DW          8
`define TBL_DEPTH       256
`define CH_W            2
`define CH_COUNT        3
`define TBL_PSEUDO      1'h0
`define TBL_RGB         1'h1
`define HOST_BUS_W      20
`define ZERO8           8'h00

`endif

//--- logic/colour_table.v
`timescale 1ns/1ps
`include "compositor_defines.vh"

// ----------------------------------------------------------------
// One 256 x 8 colour table, write port and registered read port
// ----------------------------------------------------------------
module colour_table (
  input  wire                 clk,
  input  wire                 wr_en,    // Write strobe, one cycle
  input  wire [`TBL_AW-1:0]   wr_addr,  // Write entry
  input  wire [`TBL_DW-1:0]   wr_data,  // Write value
  input  wire [`TBL_AW-1:0]   rd_addr,  // Lookup index
  output reg  [`TBL_DW-1:0]   rd_data_q // Lookup result, one cycle later
);

  reg [`TBL_DW-1:0] mem [0:`TBL_DEPTH-1]; // Table storage

  // Write and registered read; contents are undefined until loaded
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule

//--- logic/pixel_format_compositor.v
`timescale 1ns/1ps
`include "compositor_defines.vh"

module pixel_format_compositor #(
  parameter REDUCED = 0                         // 1: only 2:1 demultiplexing
) (
  input  wire                  clk,             // Dot-rate clock
  input  wire                  rst,             // Synchronous, active high
  input  wire                  pixel_input_clock, // Divided pixel clock pin
  input  wire [`WORD_W-1:0]    pixel_word,      // Multiplexed pixel pins
  input  wire [`SEL_W-1:0]     pixel_select,    // Per-pixel field select pins
  input  wire [`MODE_W-1:0]    pixel_mode,      // Pixel format setting
  input  wire [`FACTOR_W-1:0]  mux_factor,      // Demultiplex factor setting
  input  wire                  select_by_value, // Compositing setting
  input  wire [`TBL_DW-1:0]    pseudo_mask,     // Pseudo-colour mask
  input  wire                  host_write,      // Async write strobe, high
  input  wire [`CH_W-1:0]      host_channel,    // 0 red, 1 green, 2 blue
  input  wire                  host_table,      // 0 pseudo, 1 RGB
  input  wire [`TBL_AW-1:0]    host_addr,       // Table entry
  input  wire [`TBL_DW-1:0]    host_data,       // Table value
  output reg  [`TBL_DW-1:0]    red_q,           // Red converter input
  output reg  [`TBL_DW-1:0]    green_q,         // Green converter input
  output reg  [`TBL_DW-1:0]    blue_q,          // Blue converter input
  output reg                   dot_valid_q,     // Converter data valid
  output reg                   pseudo_shown_q,  // Pseudo field displayed
  output reg                   overrun_q        // Word arrived mid-burst
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Effective factor: invalid or reduced settings fall back to 2:1
  function [`FACTOR_W-1:0] eff_factor;
    input [`FACTOR_W-1:0] f;
    begin
      if (REDUCED != 0 || f < `FACTOR_MIN || f > `FACTOR_MAX) begin
        eff_factor = `FACTOR_MIN;
      end else begin
        eff_factor = f;
      end
    end
  endfunction

  // Extract one sub-pixel of the current format, lowest slot first
  function [`PIX32_W-1:0] sub_pixel;
    input [`WORD_W-1:0]   w;
    input [`MODE_W-1:0]   m;
    input [`FACTOR_W-1:0] s;
    begin
      case (m)
        `MODE_8BIT:  sub_pixel = {{(`PIX32_W-`PIX8_W){1'b0}},
                                  w[s*`PIX8_W +: `PIX8_W]};
        `MODE_16BIT: sub_pixel = {{(`PIX32_W-`PIX16_W){1'b0}},
                                  w[s*`PIX16_W +: `PIX16_W]};
        default:     sub_pixel = w[s*`PIX32_W +: `PIX32_W];
      endcase
    end
  endfunction

  // Settled rising edge: stages two and three agree high, level was low
  function settled_rise;
    input s2;
    input s3;
    input lvl;
    begin
      settled_rise = (s2 == s3) && s3 && !lvl;
    end
  endfunction

  // Last sub-pixel slot of a burst of the given factor
  function last_slot;
    input [`FACTOR_W-1:0] s;
    input [`FACTOR_W-1:0] f;
    begin
      last_slot = (s == f - `SLOT_STEP);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0]                 pclk_sync_q;  // Pixel clock stages
  reg                       pclk_lvl_q;   // Settled pixel clock level
  reg [`WORD_W-1:0]         word_s1_q;    // Pixel word stage 1
  reg [`WORD_W-1:0]         word_s2_q;    // Pixel word stage 2
  reg [`WORD_W-1:0]         word_s3_q;    // Pixel word stage 3
  reg [`SEL_W-1:0]          sel_s1_q;     // Select pins stage 1
  reg [`SEL_W-1:0]          sel_s2_q;     // Select pins stage 2
  reg [`SEL_W-1:0]          sel_s3_q;     // Select pins stage 3
  reg [`HOST_BUS_W-1:0]     host_s1_q;    // Host port stage 1
  reg [`HOST_BUS_W-1:0]     host_s2_q;    // Host port stage 2
  reg [`HOST_BUS_W-1:0]     host_s3_q;    // Host port stage 3
  reg                       host_lvl_q;   // Settled host strobe level
  wire                      pclk_rise;    // Settled pixel clock rising
  wire                      host_rise;    // Settled host strobe rising

  // Three-stage capture; data stay aligned with the clock stages
  always @(posedge clk) begin
    word_s1_q <= pixel_word;
    word_s2_q <= word_s1_q;
    word_s3_q <= word_s2_q;
    sel_s1_q  <= pixel_select;
    sel_s2_q  <= sel_s1_q;
    sel_s3_q  <= sel_s2_q;
    host_s1_q <= {host_write, host_channel, host_table, host_addr, host_data};
    host_s2_q <= host_s1_q;
    host_s3_q <= host_s2_q;
  end

  // Level only counts once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      pclk_sync_q <= 3'h0;
      pclk_lvl_q  <= 1'b0;
      host_lvl_q  <= 1'b0;
    end else begin
      pclk_sync_q <= {pclk_sync_q[1:0], pixel_input_clock};
      if (pclk_sync_q[1] == pclk_sync_q[2]) begin
        pclk_lvl_q <= pclk_sync_q[2];
      end
      if (host_s2_q[`HOST_BUS_W-1] == host_s3_q[`HOST_BUS_W-1]) begin
        host_lvl_q <= host_s3_q[`HOST_BUS_W-1];
      end
    end
  end

  // Edges count only once stages two and three agree high
  assign pclk_rise = settled_rise(pclk_sync_q[1], pclk_sync_q[2], pclk_lvl_q);
  assign host_rise = settled_rise(host_s2_q[`HOST_BUS_W-1], host_s3_q[`HOST_BUS_W-1],
                                  host_lvl_q);

  // ----------------------------------------------------------------
  // Host table writes
  // ----------------------------------------------------------------
  wire [`CH_W-1:0]   wr_ch   = host_s3_q[`HOST_BUS_W-2 -: `CH_W];  // Channel
  wire               wr_tbl  = host_s3_q[`TBL_AW+`TBL_DW];          // Table
  wire [`TBL_AW-1:0] wr_addr = host_s3_q[`TBL_DW +: `TBL_AW];       // Entry
  wire [`TBL_DW-1:0] wr_data = host_s3_q[`TBL_DW-1:0];              // Value

  // ----------------------------------------------------------------
  // Demultiplexer and dot sequencer
  // ----------------------------------------------------------------
  reg [`WORD_W-1:0]   held_word_q;  // Word being unpacked
  reg [`SEL_W-1:0]    held_sel_q;   // Select pins of that word
  reg [`FACTOR_W-1:0] factor_q;     // Factor latched per word
  reg [`FACTOR_W-1:0] slot_q;       // Sub-pixel slot
  reg                 busy_q;       // Unpacking in progress

  // Each settled input-clock edge starts a burst of factor dots
  always @(posedge clk) begin
    if (rst) begin
      held_word_q <= {`WORD_W{1'b0}};
      held_sel_q  <= {`SEL_W{1'b0}};
      factor_q    <= `FACTOR_MIN;
      slot_q      <= `SLOT_FIRST;
      busy_q      <= 1'b0;
      overrun_q   <= 1'b0;
    end else if (pclk_rise) begin
      // New word: one dot per clock, factor dots per input clock
      held_word_q <= word_s3_q;
      held_sel_q  <= sel_s3_q;
      factor_q    <= eff_factor(mux_factor);
      slot_q      <= `SLOT_FIRST;
      busy_q      <= 1'b1;
      overrun_q   <= busy_q && !last_slot(slot_q, factor_q);
    end else if (busy_q) begin
      // Advance slot, stop after the last sub-pixel
      if (last_slot(slot_q, factor_q)) begin
        busy_q <= 1'b0;
      end else begin
        slot_q <= slot_q + `SLOT_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Format decode and field selection
  // ----------------------------------------------------------------
  reg [`PIX32_W-1:0] pix;                     // Current sub-pixel
  reg [`TBL_AW-1:0]  pse_idx;                 // Masked pseudo index
  reg [`TBL_AW-1:0]  rgb_idx [0:`CH_COUNT-1]; // RGB index per channel
  reg                use_pseudo;              // Field chosen this dot

  always @* begin
    pix        = sub_pixel(held_word_q, pixel_mode, slot_q);
    rgb_idx[0] = `ZERO8;
    rgb_idx[1] = `ZERO8;
    rgb_idx[2] = `ZERO8;
    case (pixel_mode)
      `MODE_8BIT: begin
        // Whole pixel is a pseudo index for all channels
        pse_idx    = pix[`PIX8_W-1:0] & pseudo_mask;
        use_pseudo = 1'b1;
      end
      `MODE_16BIT: begin
        // Left-aligned components, low bits zero
        pse_idx    = `ZERO8;
        rgb_idx[0] = {pix[`P16_RED_HI:`P16_RED_LO], `FILL6};
        rgb_idx[1] = {pix[`P16_GRN_HI:`P16_GRN_LO], `FILL6};
        rgb_idx[2] = {pix[`P16_BLU_HI:`P16_BLU_LO], `FILL4};
        use_pseudo = 1'b0;
      end
      default: begin
        // True-colour bytes plus masked pseudo byte
        pse_idx    = pix[`P32_PSE_HI:`P32_PSE_LO] & pseudo_mask;
        rgb_idx[0] = pix[`P32_RED_HI:`P32_RED_LO];
        rgb_idx[1] = pix[`P32_GRN_HI:`P32_GRN_LO];
        rgb_idx[2] = pix[`P32_BLU_HI:`P32_BLU_LO];
        // Per-dot choice by value or by pin
        if (select_by_value) begin
          use_pseudo = (pse_idx != `ZERO8);
        end else begin
          use_pseudo = held_sel_q[slot_q];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Colour channels
  // ----------------------------------------------------------------
  wire [`TBL_DW-1:0] pse_out [0:`CH_COUNT-1]; // Pseudo table results
  wire [`TBL_DW-1:0] rgb_out [0:`CH_COUNT-1]; // RGB table results
  reg                look_valid_q;            // Lookup under way
  reg                look_pseudo_q;           // Field chosen for lookup

  // Two tables per channel, written from the host port
  genvar ch;
  generate
    for (ch = 0; ch < `CH_COUNT; ch = ch + 1) begin : chan
      colour_table pseudo_tbl (
        .clk       (clk),
        .wr_en     (host_rise && wr_ch == ch && wr_tbl == `TBL_PSEUDO),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .rd_addr   (pse_idx),
        .rd_data_q (pse_out[ch])
      );
      colour_table rgb_tbl (
        .clk       (clk),
        .wr_en     (host_rise && wr_ch == ch && wr_tbl == `TBL_RGB),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .rd_addr   (rgb_idx[ch]),
        .rd_data_q (rgb_out[ch])
      );
    end
  endgenerate

  // Match the field choice to the table read latency
  always @(posedge clk) begin
    if (rst) begin
      look_valid_q  <= 1'b0;
      look_pseudo_q <= 1'b0;
    end else begin
      look_valid_q  <= busy_q;
      look_pseudo_q <= use_pseudo;
    end
  end

  // Only the chosen field's result reaches the converters
  always @(posedge clk) begin
    if (rst) begin
      red_q          <= `ZERO8;
      green_q        <= `ZERO8;
      blue_q         <= `ZERO8;
      dot_valid_q    <= 1'b0;
      pseudo_shown_q <= 1'b0;
    end else begin
      dot_valid_q    <= look_valid_q;
      pseudo_shown_q <= look_valid_q && look_pseudo_q;
      if (!look_valid_q) begin
        red_q   <= `ZERO8;
        green_q <= `ZERO8;
        blue_q  <= `ZERO8;
      end else if (look_pseudo_q) begin
        red_q   <= pse_out[0];
        green_q <= pse_out[1];
        blue_q  <= pse_out[2];
      end else begin
        red_q   <= rgb_out[0];
        green_q <= rgb_out[1];
        blue_q  <= rgb_out[2];
      end
    end
  end

endmodule

//--- test/compositor_assertions.sv
`timescale 1ns/1ps
`include "compositor_defines.vh"
// ----------------------------------------------------------------
// Output timing and field checks
// ----------------------------------------------------------------
module compositor_assertions #(
  parameter REDUCED = 0                    // Passed on, not used here
) (
  input wire                 clk,
  input wire                 rst,
  input wire                 pixel_input_clock,
  input wire [`MODE_W-1:0]   pixel_mode,
  input wire                 select_by_value,
  input wire [`TBL_DW-1:0]   pseudo_mask,
  input wire [`TBL_DW-1:0]   red_q,
  input wire [`TBL_DW-1:0]   green_q,
  input wire [`TBL_DW-1:0]   blue_q,
  input wire                 dot_valid_q,
  input wire                 pseudo_shown_q,
  input wire                 overrun_q
);
  reg [3:0] age_q;                         // Clocks since pin rise, saturates
  // Age of the last pixel clock rise
  always @(posedge clk) begin
    if (rst) age_q <= 4'hF;
    else if ($rose(pixel_input_clock)) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_idle; !dot_valid_q |-> {red_q, green_q, blue_q} == 24'h000000; endproperty
  a_idle: assert property (p_idle) else $error("colour while idle");
  property p_show; pseudo_shown_q |-> dot_valid_q; endproperty
  a_show: assert property (p_show) else $error("pseudo flag without dot");
  property p_first; $rose(pixel_input_clock) |-> ##[5:8] dot_valid_q; endproperty
  a_first: assert property (p_first) else $error("no dot after word");
  property p_span; dot_valid_q |-> age_q <= 4'hB; endproperty
  a_span: assert property (p_span) else $error("dot too long after word");
  property p_min; $rose(dot_valid_q) |=> dot_valid_q; endproperty
  a_min: assert property (p_min) else $error("burst below two dots");
  property p_ovr; $changed(overrun_q) |-> age_q >= 4'h1 && age_q <= 4'h5; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun moved off a load");
  // Settings are taken from the dot's decode cycle, two clocks back
  property p_m8; dot_valid_q && $past(pixel_mode, 2) == `MODE_8BIT |->
    pseudo_shown_q; endproperty
  a_m8: assert property (p_m8) else $error("byte pixel not pseudo");
  property p_m16; dot_valid_q && $past(pixel_mode, 2) == `MODE_16BIT |->
    !pseudo_shown_q; endproperty
  a_m16: assert property (p_m16) else $error("packed pixel not rgb");
  property p_zero; dot_valid_q && $past(pixel_mode, 2) == `MODE_32BIT &&
    $past(select_by_value, 2) && $past(pseudo_mask, 2) == `ZERO8 |->
    !pseudo_shown_q; endproperty
  a_zero: assert property (p_zero) else $error("masked zero not rgb");
endmodule

bind pixel_format_compositor compositor_assertions #(.REDUCED(REDUCED)) i_compositor_assertions (
  .clk(clk), .rst(rst), .pixel_input_clock(pixel_input_clock), .pixel_mode(pixel_mode),
  .select_by_value(select_by_value), .pseudo_mask(pseudo_mask), .red_q(red_q),
  .green_q(green_q), .blue_q(blue_q), .dot_valid_q(dot_valid_q),
  .pseudo_shown_q(pseudo_shown_q), .overrun_q(overrun_q));

//--- test/pixel_source.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pixel word source at the divided rate
// ----------------------------------------------------------------
module pixel_source (
  input  wire         clk,
  input  wire         rst,
  input  wire         start,   // Word offered
  input  wire [159:0] w,       // Word to send
  input  wire [4:0]   s,       // Select bits to send
  input  wire [3:0]   hi,      // Clocks high
  input  wire [3:0]   lo,      // Extra clocks low
  output wire         ready,   // Word taken at this edge if offered
  output reg          pclk_q,  // Divided pixel clock
  output reg  [159:0] word_q,  // Pixel pins
  output reg  [4:0]   sel_q    // Select pins
);
  reg       run_q;             // Word in flight
  reg [4:0] n_q;               // Clocks since load
  assign ready = !run_q || n_q == hi + lo;
  // Clock and data at the divided rate, data held for the period
  always @(posedge clk) begin
    if (rst) begin
      run_q  <= 1'b0;
      pclk_q <= 1'b0;
      word_q <= 160'h0;
      sel_q  <= 5'h00;
    end else if (ready && start) begin
      run_q  <= 1'b1;
      n_q    <= 5'h00;
      word_q <= w;
      sel_q  <= s;
    end else if (ready) begin
      // Released pins change every clock
      run_q  <= 1'b0;
      word_q <= ~word_q;
      sel_q  <= ~sel_q;
    end else begin
      n_q    <= n_q + 5'h01;
      pclk_q <= n_q < hi;
    end
  end
endmodule

//--- test/pixel_format_compositor_tb_top.sv
`timescale 1ns/1ps
`include "compositor_defines.vh"
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module pixel_format_compositor_tb_top;
  reg clk, rst, host_write, host_table, select_by_value, start, loose;
  reg [1:0]   host_channel, pixel_mode;
  reg [7:0]   host_addr, host_data, pseudo_mask;
  reg [2:0]   mux_factor;
  reg [159:0] w, x;
  reg [4:0]   s;
  reg [3:0]   hi, lo;
  reg [24:0]  q[$];            // Expected {pseudo, red, green, blue}
  integer     seed, r, i, c, t, a, checks, mismatches;
  wire        pclk, ready, dot_valid_q, pseudo_shown_q, overrun_q;
  wire [159:0] pword;
  wire [4:0]  psel;
  wire [7:0]  red_q, green_q, blue_q;
  pixel_source i_pixel_source (.clk(clk), .rst(rst), .start(start), .w(w), .s(s),
    .hi(hi), .lo(lo), .ready(ready), .pclk_q(pclk), .word_q(pword), .sel_q(psel));
  pixel_format_compositor i_pixel_format_compositor (.clk(clk), .rst(rst),
    .pixel_input_clock(pclk), .pixel_word(pword), .pixel_select(psel),
    .pixel_mode(pixel_mode), .mux_factor(mux_factor), .select_by_value(select_by_value),
    .pseudo_mask(pseudo_mask), .host_write(host_write), .host_channel(host_channel),
    .host_table(host_table), .host_addr(host_addr), .host_data(host_data), .red_q(red_q),
    .green_q(green_q), .blue_q(blue_q), .dot_valid_q(dot_valid_q),
    .pseudo_shown_q(pseudo_shown_q), .overrun_q(overrun_q));
  // Table contents loaded by the bench
  function [7:0] tv(input [1:0] ch, input tb, input [7:0] ad);
    tv = ad ^ {ch, tb, 5'h0B};
  endfunction
  // Effective demultiplex factor
  function [2:0] fe(input [2:0] f);
    fe = (f >= 3'h2 && f <= 3'h5) ? f : 3'h2;
  endfunction
  // Expected dot for slot k
  function [24:0] dot(input [159:0] wd, input [4:0] sl, input [2:0] k);
    reg [31:0] p;
    reg [7:0]  m;
    begin
      p = wd[k*32 +: 32];
      m = (pixel_mode == `MODE_8BIT ? wd[k*8 +: 8] : p[7:0]) & pseudo_mask;
      dot = {1'b1, tv(2'h0, 1'h0, m), tv(2'h1, 1'h0, m), tv(2'h2, 1'h0, m)};
      if (pixel_mode == `MODE_16BIT) begin
        p = wd[k*16 +: 16];
        dot = {1'b0, tv(2'h0, 1'h1, {p[15:10], 2'h0}), tv(2'h1, 1'h1, {p[9:4], 2'h0}),
          tv(2'h2, 1'h1, {p[3:0], 4'h0})};
      end else if (pixel_mode != `MODE_8BIT && !(select_by_value ? m != 8'h00 : sl[k])) begin
        dot = {1'b0, tv(2'h0, 1'h1, p[31:24]), tv(2'h1, 1'h1, p[23:16]), tv(2'h2, 1'h1, p[15:8])};
      end
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task cmp_dot(input [24:0] e);
    begin
      checks = checks + 1;
      if ({pseudo_shown_q, red_q, green_q, blue_q} !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR dot exp %h got %h", e, {pseudo_shown_q, red_q, green_q, blue_q});
      end
    end
  endtask
  task cmp_flag(input e, input g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR overrun exp %b got %b", e, g);
      end
    end
  endtask
  // One table write through the host strobe
  task hwr(input [1:0] ch, input tb, input [7:0] ad, input [7:0] d);
    begin
      @(negedge clk);
      {host_channel, host_table, host_addr, host_data} = {ch, tb, ad, d};
      host_write = 1'b1;
      repeat (6) @(negedge clk);
      host_write = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  // Offer one random word and queue its dots
  task go;
    integer j, b;
    begin
      for (j = 0; j < 5; j = j + 1) x = {x[127:0], $random(seed)};
      r = $random(seed);
      @(negedge clk);
      {w, s, start} = {x, r[4:0], 1'b1};
      for (j = 0; j < fe(mux_factor); j = j + 1) q.push_back(dot(x, r[4:0], j[2:0]));
      b = 0;
      @(posedge clk);
      while (ready !== 1'b1) begin
        b = b + 1;
        if (b > 40) begin mismatches = mismatches + 1; test_done; end
        @(posedge clk);
      end
    end
  endtask
  // Stop offering and wait for all dots
  task drain;
    integer b;
    begin
      @(negedge clk);
      start = 1'b0;
      for (b = 0; q.size() != 0; b = b + 1) begin
        if (b > 100) begin mismatches = mismatches + 1; test_done; end
        @(posedge clk);
      end
      repeat (3) @(negedge clk);
    end
  endtask
  // Dot collector
  always @(posedge clk) begin
    if (!rst && !loose && dot_valid_q === 1'b1) begin
      if (q.size() == 0) cmp_dot({25{1'bx}});
      else cmp_dot(q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, host_write, host_table, select_by_value, start, loose} = 6'h20;
    {host_channel, pixel_mode, host_addr, host_data, pseudo_mask, mux_factor} = 31'h0;
    {w, x, s, hi, lo, checks, mismatches, seed} = {325'h0, 8'h33, 64'h0, 32'h80E4};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (c = 0; c < 4; c = c + 1)
      for (t = 0; t < 2; t = t + 1)
        for (a = 0; a < 256; a = a + 1)
          hwr(c[1:0], t[0], a[7:0], c == 3 ? ~a[7:0] : tv(c[1:0], t[0], a[7:0]));
    for (i = 0; i < 48; i = i + 1) begin
      r = $random(seed);
      {select_by_value, pseudo_mask, mux_factor, pixel_mode} = {r[0], r[15:8], r[18:16], r[21:20]};
      if (i < 4) pixel_mode = i[1:0];
      if (i < 8) mux_factor = i[2:0];
      if (i % 3 == 2) {select_by_value, pseudo_mask} = 9'h100;
      go;
      drain;
    end
    {hi, lo, pixel_mode, mux_factor} = {8'h21, 2'h2, 3'h4};
    for (i = 0; i < 6; i = i + 1) go;
    drain;
    {loose, mux_factor} = {1'b1, 3'h5};
    go;
    go;
    @(negedge clk);
    start = 1'b0;
    repeat (20) @(negedge clk);
    cmp_flag(1'b1, overrun_q);
    q.delete();
    {loose, hi, lo} = {1'b0, 8'h33};
    go;
    drain;
    cmp_flag(1'b0, overrun_q);
    test_done;
  end
endmodule
